// ---- rtl/tmsp_cfg.svh ----
// Constants for the touch matrix scan and power controller.
// Operation
// - Burst code 0..3 gives 16/32/48/64 pulses.
// - Suppression enabled individually per key.
// - Suppressed key loses to more negative peer.
// - Compare raw deviations, ignore gain and threshold.
// - Suppression defaults to off for all keys.
// - Sync pulse brackets bursts of selected keys.
// - Scope pulse selection defaults to off.
// - Line wait only before lowest enabled key.
// - Before scan wait for falling line edge.
// - Without edge, scan after full wait expires.
// - Line edges ignored while sleeping.
// - Line sync single bit, default off.
// - Sleep period from eight-entry table, default 125ms.
// - Independent wake enable for every key.
// - Serial bus mode: wake touch sets detect.
// - Shift mode: wake touch extends awake period.
// - Shift mode: after wake touch, any touch extends awake.
// - Wake enable defaults to on.
// - After scan sleep unless held awake.
// - Serial bus mode: host traffic holds awake.
// - After wake, sleep only after idle timeout.
// - Awake timeout one byte, 100ms steps.
// - Option bit 6 suppression, bit 7 scope.
// - Option bit 3 wake, bits 5:4 burst.
// - Setup bit 6 line sync, bits 2:0 sleep.
`ifndef TMSP_CFG_SVH
`define TMSP_CFG_SVH
`define OPT_WAKE_BIT 3
`define OPT_BL_LSB 4
`define OPT_SUPP_BIT 6
`define OPT_SCOPE_BIT 7
`define SET_LINE_BIT 6
`define SET_SLEEP_LSB 0
`define DEF_KEY_OPT 8'h28
`define DEF_SETUP 8'h03
`define DEF_AWAKE 8'hFF
`define BL_STEP 7'h10
`define CLK_HZ 32'h0131_2D00
`define MS_PER_S 32'h0000_03E8
`define MS_CYCLES (`CLK_HZ / `MS_PER_S)
`define SYNC_WAIT_MS 7'h64
`define AWAKE_STEP_MS 15'h0064
`define SLEEP_MS_0 11'h010
`define SLEEP_MS_1 11'h020
`define SLEEP_MS_2 11'h040
`define SLEEP_MS_3 11'h07D
`define SLEEP_MS_4 11'h0FA
`define SLEEP_MS_5 11'h1F4
`define SLEEP_MS_6 11'h3E8
`define SLEEP_MS_7 11'h7D0
`endif

// ---- rtl/tmsp_pkg.sv ----
// Types shared by the scan and power controller modules.
package tmsp_pkg;
  typedef enum logic [5:0] {
    TMSP_ST_DONE  = 6'h01,
    TMSP_ST_SLEEP = 6'h02,
    TMSP_ST_SYNC  = 6'h04,
    TMSP_ST_PRE   = 6'h08,
    TMSP_ST_BURST = 6'h10,
    TMSP_ST_POST  = 6'h20
  } tmsp_state_t;
endpackage

// ---- rtl/tmsp_evt_if.sv ----
// Timing tick and synchronised pin levels passed to the scan core.
`timescale 1ns/10ps
interface tmsp_evt_if;
  logic ms_tick;
  logic [1:0] lvl;
  modport tick_src (output ms_tick);
  modport sync_src (output lvl);
  modport core (input ms_tick, input lvl);
endinterface

// ---- rtl/tmsp_sync3.sv ----
// Three-stage synchroniser with agreement filter for asynchronous levels.
`timescale 1ns/10ps
module tmsp_sync3 #(
  parameter int W = 2
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  tmsp_evt_if.sync_src evt
);
  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] lvl;
  } tmsp_sync_t;
  tmsp_sync_t s_q;
  tmsp_sync_t s_d;

  // A bit only moves once the second and third stages agree, so a
  // late-settling first stage cannot produce a false edge.
  always_comb begin
    s_d = s_q;
    s_d.ff1 = i_async;
    s_d.ff2 = s_q.ff1;
    s_d.ff3 = s_q.ff2;
    for (int i = 0; i < W; i++) begin
      if (s_q.ff2[i] == s_q.ff3[i]) begin
        s_d.lvl[i] = s_q.ff3[i];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign evt.lvl = s_q.lvl;
endmodule

// ---- rtl/tmsp_tick.sv ----
// Millisecond tick generator for the sleep, sync and awake timers.
`timescale 1ns/10ps
module tmsp_tick #(
  parameter int P_MS_CYCLES = 20000
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  tmsp_evt_if.tick_src evt
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } tmsp_tick_t;
  tmsp_tick_t t_q;
  tmsp_tick_t t_d;

  always_comb begin
    t_d = t_q;
    t_d.tick = 1'b0;
    if (t_q.cnt >= 32'(P_MS_CYCLES - 1)) begin
      t_d.cnt = '0;
      t_d.tick = 1'b1;
    end else begin
      t_d.cnt = t_q.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      t_q <= '0;
    end else begin
      t_q <= t_d;
    end
  end

  assign evt.ms_tick = t_q.tick;
endmodule

// ---- rtl/tmsp_core.sv ----
// Scan sequencer, key suppression and sleep/awake control of the touch matrix.
`timescale 1ns/10ps
`include "tmsp_cfg.svh"
module tmsp_core import tmsp_pkg::*; #(
  parameter int N = 16,
  parameter int DW = 16,
  parameter int P_MS_CYCLES = `MS_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_link_clk,
  input wire logic i_link_txn,
  input wire logic i_cfg_default,
  input wire logic [N*8-1:0] i_key_opt,
  input wire logic [N-1:0] i_key_en,
  input wire logic [7:0] i_setup,
  input wire logic [7:0] i_awake_setting,
  input wire logic i_sel_i2c,
  input wire logic [N*DW-1:0] i_key_delta,
  input wire logic [N-1:0] i_key_detect,
  input wire logic i_line_sync,
  output logic o_burst_active,
  output logic [((N > 1) ? $clog2(N) : 1)-1:0] o_burst_key,
  output logic o_xfer_pulse,
  output logic [6:0] o_burst_len,
  output logic o_scope_sync,
  output logic o_sleeping,
  output logic o_awake_hold,
  output logic [N-1:0] o_key_report,
  output logic o_detect
);
  localparam int KW = (N > 1) ? $clog2(N) : 1;

  typedef struct packed {
    tmsp_state_t state;
    logic [KW-1:0] key;
    logic [6:0] pcnt;
    logic [6:0] len;
    logic [10:0] sleep_ms;
    logic [6:0] wait_ms;
    logic [14:0] awake_ms;
    logic woke;
    logic scope;
    logic xfer;
    logic detect;
    logic line_prev;
    logic host_prev;
    logic [N-1:0] report;
  } tmsp_core_t;

  tmsp_core_t st_q;
  tmsp_core_t st_d;
  logic lk_tog_q;
  tmsp_evt_if evt ();

  logic [N-1:0] wake_en;
  logic [N-1:0] supp_en;
  logic [N-1:0] scope_en;
  logic [N-1:0] supp;
  logic [1:0] bl_code [N];
  logic [7:0] setup;
  logic [7:0] awake_set;
  logic line_en;
  logic [14:0] awake_full;
  logic line_fall;
  logic host_evt;
  logic [6:0] len_cur;
  logic [KW:0] first_en;

  // Host traffic happens on the link clock; a toggle carries each
  // transaction across so no event is lost between unrelated clocks.
  always_ff @(posedge i_link_clk) begin
    if (!i_rst_n) begin
      lk_tog_q <= 1'b0;
    end else if (i_link_txn) begin
      lk_tog_q <= ~lk_tog_q;
    end
  end

  tmsp_sync3 #(
    .W(2)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async({lk_tog_q, i_line_sync}),
    .evt(evt.sync_src)
  );

  tmsp_tick #(
    .P_MS_CYCLES(P_MS_CYCLES)
  ) u_tick (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .evt(evt.tick_src)
  );

  function automatic logic [6:0] bl_pulses(input logic [1:0] code);
    return 7'({3'b000, code, 4'h0} + `BL_STEP);
  endfunction

  function automatic logic [10:0] sleep_period(input logic [2:0] idx);
    logic [10:0] r;
    case (idx)
      3'h0: r = `SLEEP_MS_0;
      3'h1: r = `SLEEP_MS_1;
      3'h2: r = `SLEEP_MS_2;
      3'h3: r = `SLEEP_MS_3;
      3'h4: r = `SLEEP_MS_4;
      3'h5: r = `SLEEP_MS_5;
      3'h6: r = `SLEEP_MS_6;
      3'h7: r = `SLEEP_MS_7;
      default: r = `SLEEP_MS_3;
    endcase
    return r;
  endfunction

  // Returns the lowest enabled key at or above lo, found flag on top.
  function automatic logic [KW:0] find_en(input logic [N-1:0] en, input int lo);
    logic [KW:0] r;
    r = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (en[i] && i >= lo) begin
        r = {1'b1, KW'(i)};
      end
    end
    return r;
  endfunction

  assign setup = i_cfg_default ? `DEF_SETUP : i_setup;
  assign awake_set = i_cfg_default ? `DEF_AWAKE : i_awake_setting;
  assign line_en = setup[`SET_LINE_BIT];
  assign awake_full = 15'({7'h00, awake_set} * `AWAKE_STEP_MS);

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_key
      logic [7:0] opt;
      logic beaten;
      assign opt = i_cfg_default ? `DEF_KEY_OPT : i_key_opt[g*8 +: 8];
      assign wake_en[g] = opt[`OPT_WAKE_BIT];
      assign bl_code[g] = opt[`OPT_BL_LSB +: 2];
      assign supp_en[g] = opt[`OPT_SUPP_BIT];
      assign scope_en[g] = opt[`OPT_SCOPE_BIT];
      // raw deviation comparison among suppression-enabled keys
      always_comb begin
        beaten = 1'b0;
        for (int j = 0; j < N; j++) begin
          if (j != g && supp_en[j] &&
              $signed(i_key_delta[j*DW +: DW]) < $signed(i_key_delta[g*DW +: DW])) begin
            beaten = 1'b1;
          end
        end
      end
      assign supp[g] = supp_en[g] & beaten;
    end
  endgenerate

  // Edges are taken only from the filtered levels, never the raw pins.
  assign line_fall = st_q.line_prev & ~evt.lvl[0];
  assign host_evt = st_q.host_prev ^ evt.lvl[1];
  assign len_cur = bl_pulses(bl_code[st_q.key]);
  assign first_en = find_en(i_key_en, 0);

  always_comb begin
    logic [KW:0] nx;
    logic [N-1:0] touch;
    logic wake_hit;
    logic any_touch;
    logic reload;
    logic start;
    logic go_first;
    nx = '0;
    touch = i_key_detect & ~supp;
    wake_hit = |(touch & wake_en);
    any_touch = |touch;
    reload = 1'b0;
    start = 1'b0;
    go_first = 1'b0;
    st_d = st_q;
    st_d.line_prev = evt.lvl[0];
    st_d.host_prev = evt.lvl[1];
    st_d.report = touch;
    // detect output on wake key touch, serial bus mode only
    st_d.detect = i_sel_i2c & wake_hit;

    // host traffic restarts the awake timer
    if (i_sel_i2c) begin
      reload = host_evt;
    end else begin
      // wake touch, then any touch, extends awake
      reload = wake_hit | (st_q.woke & any_touch);
    end
    // awake ends only after a full idle timeout
    if (reload) begin
      st_d.awake_ms = awake_full;
      if (wake_hit && !i_sel_i2c) begin
        st_d.woke = 1'b1;
      end
    end else if (st_q.awake_ms == '0) begin
      st_d.woke = 1'b0;
    end else if (evt.ms_tick) begin
      st_d.awake_ms = st_q.awake_ms - 15'h0001;
    end

    case (st_q.state)
      TMSP_ST_DONE: begin
        // sleep straight after a scan unless held
        if (st_q.awake_ms != '0 || reload) begin
          start = 1'b1;
        end else begin
          st_d.state = TMSP_ST_SLEEP;
          st_d.sleep_ms = sleep_period(setup[`SET_SLEEP_LSB +: 3]);
        end
      end
      TMSP_ST_SLEEP: begin
        // the line input is not looked at here
        if (evt.ms_tick) begin
          if (st_q.sleep_ms <= 11'h001) begin
            start = 1'b1;
          end else begin
            st_d.sleep_ms = st_q.sleep_ms - 11'h001;
          end
        end
      end
      TMSP_ST_SYNC: begin
        // falling line edge starts the scan
        if (line_fall) begin
          go_first = 1'b1;
        end else if (evt.ms_tick) begin
          // give up after the full wait
          if (st_q.wait_ms >= `SYNC_WAIT_MS - 7'h01) begin
            go_first = 1'b1;
          end else begin
            st_d.wait_ms = st_q.wait_ms + 7'h01;
          end
        end
      end
      TMSP_ST_PRE: begin
        st_d.state = TMSP_ST_BURST;
        st_d.pcnt = '0;
      end
      TMSP_ST_BURST: begin
        // burst ends after the decoded pulse count
        if (st_q.pcnt >= len_cur - 7'h01) begin
          st_d.state = TMSP_ST_POST;
        end else begin
          st_d.pcnt = st_q.pcnt + 7'h01;
        end
      end
      TMSP_ST_POST: begin
        nx = find_en(i_key_en, int'(st_q.key) + 1);
        if (nx[KW]) begin
          st_d.state = TMSP_ST_PRE;
          st_d.key = nx[KW-1:0];
        end else begin
          st_d.state = TMSP_ST_DONE;
        end
      end
      default: begin
        st_d.state = TMSP_ST_DONE;
      end
    endcase

    // the line wait precedes only the first key of a scan
    if (start) begin
      if (line_en) begin
        st_d.state = TMSP_ST_SYNC;
        st_d.wait_ms = '0;
      end else begin
        go_first = 1'b1;
      end
    end
    if (go_first) begin
      if (first_en[KW]) begin
        st_d.state = TMSP_ST_PRE;
        st_d.key = first_en[KW-1:0];
      end else begin
        st_d.state = TMSP_ST_DONE;
      end
    end

    // scope pulse covers pre, burst and post of selected keys
    st_d.scope = scope_en[st_d.key] &
                 (st_d.state == TMSP_ST_PRE || st_d.state == TMSP_ST_BURST || st_d.state == TMSP_ST_POST);
    st_d.xfer = (st_d.state == TMSP_ST_BURST);
    st_d.len = bl_pulses(bl_code[st_d.key]);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_q <= '{state: TMSP_ST_DONE, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_burst_active = st_q.xfer;
  assign o_burst_key = st_q.key;
  assign o_xfer_pulse = st_q.xfer;
  assign o_burst_len = st_q.len;
  assign o_scope_sync = st_q.scope;
  assign o_sleeping = (st_q.state == TMSP_ST_SLEEP);
  assign o_awake_hold = (st_q.awake_ms != '0);
  assign o_key_report = st_q.report;
  assign o_detect = st_q.detect;

  // burst keeps going until the decoded count
  burst_len_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (st_q.state == TMSP_ST_BURST && st_q.pcnt < len_cur - 7'h01) |=> (st_q.state == TMSP_ST_BURST))
    else $error("burst ended before its pulse count");

  // burst stops exactly at the decoded count
  burst_end_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (st_q.state == TMSP_ST_BURST && st_q.pcnt == len_cur - 7'h01) |=> (st_q.state == TMSP_ST_POST))
    else $error("burst ran past its pulse count");

  supp_block_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    ##1 ((st_q.report & $past(supp)) == '0))
    else $error("suppressed key reported a touch");

  // scope pulse frames the selected burst
  scope_frame_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (st_q.state == TMSP_ST_PRE && scope_en[st_q.key]) |-> o_scope_sync ##1 o_scope_sync)
    else $error("scope pulse not framing burst");

  // the wait is followed by the first enabled key
  sync_first_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    ($past(st_q.state) == TMSP_ST_SYNC && st_q.state == TMSP_ST_PRE) |-> ({1'b1, st_q.key} == $past(first_en)))
    else $error("line wait not before lowest key");

  // the line wait stays within its limit
  sync_limit_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (st_q.state == TMSP_ST_SYNC) |-> (st_q.wait_ms < `SYNC_WAIT_MS))
    else $error("line wait exceeded its limit");

  // sleep does not end early on a line edge
  sleep_hold_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (st_q.state == TMSP_ST_SLEEP && st_q.sleep_ms > 11'h001) |=> (st_q.state == TMSP_ST_SLEEP))
    else $error("sleep ended early");

  // an idle scan end goes to sleep next
  sleep_gate_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (st_q.state == TMSP_ST_DONE && st_q.awake_ms == '0 && !st_q.woke && st_d.awake_ms == '0) |=>
      (st_q.state == TMSP_ST_SLEEP))
    else $error("did not sleep after idle scan");

  // host traffic loads the full timeout
  host_hold_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_sel_i2c && host_evt) |=> (st_q.awake_ms == $past(awake_full)))
    else $error("host traffic did not restart awake timer");
endmodule

// ---- dv/tmsp_host_model.sv ----
// Host model that issues transactions on the host link clock.
`timescale 1ns/10ps
module tmsp_host_model (
  input wire logic i_link_clk,
  output logic o_txn
);
  initial o_txn = 1'b0;
  // host transaction pulse.
  // The pulse spans one whole link cycle, so the core cannot miss it.
  task automatic send();
    @(negedge i_link_clk);
    o_txn = 1'b1;
    @(negedge i_link_clk);
    o_txn = 1'b0;
  endtask
endmodule

// ---- dv/tmsp_core_bench.sv ----
// Self-checking bench for the touch matrix scan and power controller.
`timescale 1ns/10ps
module tmsp_core_bench;
  import tmsp_pkg::*;
  localparam int N = 4;
  localparam int DW = 8;
  localparam int MS = 20;
  logic clk = 1'b0, rst_n = 1'b0, link_clk = 1'b0, txn, cfg_def, sel_i2c, line;
  logic [N*8-1:0] opt;
  logic [N-1:0] en, det, rep;
  logic [7:0] setup, awake;
  logic [N*DW-1:0] delta;
  logic bact, xfer, scope, sleeping, hold, detect;
  logic [1:0] bkey;
  logic [6:0] blen;
  int err_total = 0, n_compared = 0, cyc = 0, n;
  int xcnt[N], scnt[N];

  tmsp_core #(.N(N), .DW(DW), .P_MS_CYCLES(MS)) u_tmsp_core (
    .i_clk(clk), .i_rst_n(rst_n), .i_link_clk(link_clk), .i_link_txn(txn),
    .i_cfg_default(cfg_def), .i_key_opt(opt), .i_key_en(en), .i_setup(setup),
    .i_awake_setting(awake), .i_sel_i2c(sel_i2c), .i_key_delta(delta),
    .i_key_detect(det), .i_line_sync(line), .o_burst_active(bact),
    .o_burst_key(bkey), .o_xfer_pulse(xfer), .o_burst_len(blen),
    .o_scope_sync(scope), .o_sleeping(sleeping), .o_awake_hold(hold),
    .o_key_report(rep), .o_detect(detect)
  );
  tmsp_host_model u_tmsp_host_model (.i_link_clk(link_clk), .o_txn(txn));

  always #25 clk = ~clk;
  // The link clock starts off phase with the system clock.
  initial begin
    #7;
    forever #80 link_clk = ~link_clk;
  end

  // Outputs are counted mid-cycle, where they have settled.
  always @(negedge clk) begin
    cyc++;
    if (xfer === 1'b1) xcnt[bkey]++;
    if (scope === 1'b1) scnt[bkey]++;
    if (cyc == 40000) begin
      err_total++;
      $display("mismatch at %0t: run did not finish", $time);
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return sleeping;
      1: return bact;
      default: return hold;
    endcase
  endfunction

  // Waits at falling edges for a status level, bounded by lim cycles.
  task automatic wait_sig(input int w, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (pick(w) !== v && cnt < lim) begin
      @(negedge clk);
      cnt++;
    end
    chk(cnt < lim, 1'b1, "wait bound");
  endtask

  task automatic clr();
    foreach (xcnt[k]) begin
      xcnt[k] = 0;
      scnt[k] = 0;
    end
  endtask

  task automatic t_defaults();
    cfg_def = 1'b1;
    en = 4'h3;
    wait_sig(0, 1'b1, 20, n); // sleep when not held.
    clr();
    wait_sig(0, 1'b0, 3000, n); // sleep ends.
    chk(n > 2440 && n < 2560, 1'b1, "default sleep period"); // default index.
    wait_sig(0, 1'b1, 1000, n); // sleep after scan.
    chk(xcnt[0], 48, "default burst key0"); // default code.
    chk(xcnt[1], 48, "default burst key1"); // default code.
    chk(blen, 48, "default burst length port"); // default code.
    chk(scnt[0] + scnt[1], 0, "scope default"); // scope off.
    delta = {8'h00, 8'h00, 8'hF7, 8'hFB};
    det = 4'h3;
    repeat (2) @(negedge clk);
    chk(rep, 4'h3, "no default suppression"); // suppression off.
    chk(detect, 1'b1, "wake detect"); // wake default on.
  endtask

  task automatic t_burst_scope();
    cfg_def = 1'b0;
    det = 4'h0;
    en = 4'hF;
    opt = {8'h30, 8'h20, 8'h90, 8'h00};
    wait_sig(0, 1'b1, 3000, n); // sleep after scan.
    wait_sig(0, 1'b0, 2600, n); // sleep ends.
    clr();
    wait_sig(0, 1'b1, 1000, n); // sleep after scan.
    for (int k = 0; k < N; k++) begin
      chk(xcnt[k], 16 * (k + 1), "burst length"); // code table.
    end
    chk(blen, 64, "burst length port"); // code 3.
    chk(scnt[0] + scnt[1] + scnt[2] + scnt[3], 34, "scope width"); // bracket.
    wait_sig(0, 1'b0, 400, n); // sleep ends.
    chk(n >= 300 && n <= 345, 1'b1, "sleep index 0"); // table.
  endtask

  task automatic t_suppress();
    opt = {8'h40, 8'h70, 8'h00, 8'h40};
    delta = {8'h00, 8'hF7, 8'hEC, 8'hFB};
    det = 4'h7;
    repeat (2) @(negedge clk);
    chk(rep, 4'h6, "weaker peer suppressed"); // raw compare.
    chk(detect, 1'b0, "no wake key touched"); // wake bit off.
    delta[7:0] = 8'hF4;
    repeat (2) @(negedge clk);
    chk(rep, 4'h3, "stronger key wins"); // ignores burst length.
    det = 4'h0;
  endtask

  task automatic t_line();
    setup = 8'h40;
    wait_sig(0, 1'b1, 3000, n); // sleep after scan.
    repeat (40) @(negedge clk);
    line = 1'b0;
    repeat (20) @(negedge clk);
    line = 1'b1;
    wait_sig(0, 1'b0, 400, n); // sleep ends.
    wait_sig(1, 1'b1, 2200, n); // scan after wait.
    chk(n >= 1950, 1'b1, "full line wait"); // edge in sleep ignored.
    wait_sig(0, 1'b1, 400, n);
    chk(n < 250, 1'b1, "no wait between keys"); // lowest key only.
    wait_sig(0, 1'b0, 400, n); // sleep ends.
    repeat (100) @(negedge clk);
    line = 1'b0;
    wait_sig(1, 1'b1, 20, n); // scan starts on falling edge.
    line = 1'b1;
    setup = 8'h00;
  endtask

  task automatic t_awake();
    awake = 8'h02;
    wait_sig(0, 1'b1, 3000, n); // sleep after scan.
    u_tmsp_host_model.send(); // host transaction.
    // The host returns on its own clock; realign to the bench edge.
    @(negedge clk);
    wait_sig(2, 1'b1, 20, n); // host traffic holds awake.
    wait_sig(2, 1'b0, 4200, n);
    chk(n >= 3900, 1'b1, "awake period"); // steps of 100ms.
    sel_i2c = 1'b0;
    opt = {8'h00, 8'h00, 8'h00, 8'h08};
    det = 4'h1;
    wait_sig(2, 1'b1, 20, n); // wake key extends.
    chk(detect, 1'b0, "no detect in shift mode"); // serial mode only.
    det = 4'h0;
    repeat (3000) @(negedge clk);
    det = 4'h2;
    repeat (5) @(negedge clk);
    det = 4'h0;
    repeat (3000) @(negedge clk);
    chk(hold, 1'b1, "any key extends"); // after wake.
    wait_sig(2, 1'b0, 1200, n); // idle timeout.
    wait_sig(0, 1'b1, 400, n); // sleep after scan.
  endtask

  initial begin
    cfg_def = 1'b0;
    sel_i2c = 1'b1;
    line = 1'b1;
    opt = '0;
    en = '0;
    det = '0;
    setup = 8'h00;
    awake = 8'h01;
    delta = '0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_defaults();
    t_burst_scope();
    t_suppress();
    t_line();
    t_awake();
    tally_and_finish();
  end
endmodule
